//--- rtl/vtf_cfg.svh
// Constants of the tag frame filter: byte positions, tag layout, identifiers
`ifndef VTF_CFG_SVH
`define VTF_CFG_SVH

// ****************************************
// Tag protocol identifiers
// ****************************************
`define VTF_TPID_CTAG 16'h8100
`define VTF_TPID_STAG 16'h88a8

// ****************************************
// Byte index of the last byte of each header word, and the ceiling at which the byte counter holds
// ****************************************
`define VTF_IDX_OUTER_TPID 8'h0d
`define VTF_IDX_OUTER_TCI 8'h0f
`define VTF_IDX_INNER_TPID 8'h11
`define VTF_IDX_INNER_TCI 8'h13
`define VTF_IDX_MAX 8'hff

// ****************************************
// Tag control word layout
// ****************************************
`define VTF_PCP_MSB 15
`define VTF_PCP_LSB 13
`define VTF_DEI_BIT 12
`define VTF_VID_MSB 11
`define VTF_VID_LSB 0

// ****************************************
// Rule slots of one filter
// ****************************************
`define VTF_NRULE 5
`define VTF_R_SVID 0
`define VTF_R_SPCP 1
`define VTF_R_SDEI 2
`define VTF_R_CVID 3
`define VTF_R_CPCP 4

`endif

//--- rtl/vtf_pkg.sv
// Types of the tag frame filter
package vtf_pkg;

  // Match mode of one field rule
  typedef enum logic [0:0] {
    VTF_IGNORE = 1'h0,
    VTF_EQUAL = 1'h1
  } vtf_mode_type;

  // Header parser states
  typedef enum logic [4:0] {
    VTF_ST_IDLE = 5'h01,
    VTF_ST_HDR = 5'h02,
    VTF_ST_STAG = 5'h04,
    VTF_ST_CTAG = 5'h08,
    VTF_ST_SKIP = 5'h10
  } vtf_state_type;

endpackage

//--- rtl/vtf_rule_cmp.sv
// One field rule: mode, presence of the tag level and equality compare
module vtf_rule_cmp (
  // Rule setting
  input wire vtf_pkg::vtf_mode_type i_mode,
  input wire logic [11:0] i_want,
  // Frame field
  input wire logic i_present,
  input wire logic [11:0] i_field,
  // Result
  output logic o_enabled,
  output logic o_hit
);
  import vtf_pkg::*;

  wire logic equal_w;

  assign o_enabled = (i_mode == VTF_EQUAL);
  assign equal_w = (i_want == i_field);
  // Missing tag level never hits
  assign o_hit = o_enabled & i_present & equal_w;

endmodule

//--- rtl/vtf_filter.sv
// Tag frame filter: parses received frame headers and judges them on their tags
`include "vtf_cfg.svh"

module vtf_filter (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Received byte stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sof,
  input wire logic i_rx_eof,
  // Service tag rules
  input wire vtf_pkg::vtf_mode_type i_svid_mode,
  input wire logic [9:0] i_svid_value,
  input wire vtf_pkg::vtf_mode_type i_spcp_mode,
  input wire logic [2:0] i_spcp_value,
  input wire vtf_pkg::vtf_mode_type i_sdei_mode,
  input wire logic i_sdei_value,
  // Customer tag rules
  input wire vtf_pkg::vtf_mode_type i_cvid_mode,
  input wire logic [9:0] i_cvid_value,
  input wire vtf_pkg::vtf_mode_type i_cpcp_mode,
  input wire logic [2:0] i_cpcp_value,
  // Other field rules of the same filter
  input wire logic i_ext_rule_en,
  input wire logic i_ext_rule_hit,
  // Verdict
  output logic o_verdict_valid,
  output logic o_pass,
  output logic o_block,
  output logic [1:0] o_tag_count,
  output logic [`VTF_NRULE-1:0] o_rule_en,
  output logic [`VTF_NRULE-1:0] o_rule_hit
);
  import vtf_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic tpid_is_ctag(input logic [15:0] word);
    tpid_is_ctag = (word == `VTF_TPID_CTAG);
  endfunction

  function automatic logic tpid_is_stag(input logic [15:0] word);
    tpid_is_stag = (word == `VTF_TPID_STAG);
  endfunction

  function automatic logic [11:0] tci_vid(input logic [15:0] tci);
    tci_vid = tci[`VTF_VID_MSB:`VTF_VID_LSB];
  endfunction

  function automatic logic [11:0] tci_pcp(input logic [15:0] tci);
    tci_pcp = {9'h000, tci[`VTF_PCP_MSB:`VTF_PCP_LSB]};
  endfunction

  function automatic logic [11:0] tci_dei(input logic [15:0] tci);
    tci_dei = {11'h000, tci[`VTF_DEI_BIT]};
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  vtf_state_type st_q, st_d;
  logic [7:0] cnt_q;
  logic [7:0] prev_q;
  logic has_s_q, has_c_q;
  logic [15:0] s_tci_q, c_tci_q;
  logic eval_q;
  logic ext_en_q, ext_hit_q;
  vtf_mode_type svid_mode_q, spcp_mode_q, sdei_mode_q, cvid_mode_q, cpcp_mode_q;
  logic [9:0] svid_val_q, cvid_val_q;
  logic [2:0] spcp_val_q, cpcp_val_q;
  logic sdei_val_q;
  logic verdict_valid_q, pass_q, block_q;
  logic [1:0] tag_count_q;
  logic [`VTF_NRULE-1:0] rule_en_q, rule_hit_q;

  wire logic take_w;
  wire logic restart_w;
  wire logic last_w;
  wire logic frame_live_w;
  wire logic [7:0] idx_w;
  wire logic [7:0] cnt_next_w;
  wire logic [15:0] word_w;
  wire logic at_outer_tpid_w;
  wire logic at_inner_tpid_w;
  wire logic [7:0] c_tci_idx_w;
  wire logic s_cap_w, c_cap_w;
  wire logic double_w, lone_w;
  wire logic s_present_w, c_present_w;
  wire logic [15:0] s_tci_w, c_tci_w;
  wire vtf_mode_type mode_a [`VTF_NRULE];
  wire logic [11:0] want_a [`VTF_NRULE];
  wire logic [11:0] field_a [`VTF_NRULE];
  wire logic present_a [`VTF_NRULE];
  wire logic [`VTF_NRULE-1:0] en_w, hit_w;
  wire logic any_en_w, all_ok_w, pass_w;

  // ****************************************
  // Byte position within the frame
  // ****************************************
  assign take_w = i_rx_valid;
  // A start always restarts parsing, so a lost end cannot wedge the parser
  assign restart_w = take_w & i_rx_sof;
  assign last_w = take_w & i_rx_eof;
  assign frame_live_w = (st_q != VTF_ST_IDLE) | i_rx_sof;
  assign idx_w = i_rx_sof ? 8'h00 : cnt_q;
  assign cnt_next_w = (idx_w == `VTF_IDX_MAX) ? idx_w : idx_w + 8'h01;
  assign word_w = {prev_q, i_rx_data};

  // ****************************************
  // Header parser
  // ****************************************
  assign at_outer_tpid_w = take_w & (idx_w == `VTF_IDX_OUTER_TPID);
  assign at_inner_tpid_w = take_w & (idx_w == `VTF_IDX_INNER_TPID);
  assign c_tci_idx_w = has_s_q ? `VTF_IDX_INNER_TCI : `VTF_IDX_OUTER_TCI;
  assign s_cap_w = take_w & (st_q == VTF_ST_STAG) & (idx_w == `VTF_IDX_OUTER_TCI);
  assign c_cap_w = take_w & (st_q == VTF_ST_CTAG) & (idx_w == c_tci_idx_w);

  always_comb begin
    st_d = st_q;
    if (last_w) begin
      st_d = VTF_ST_IDLE;
    end else if (restart_w) begin
      st_d = VTF_ST_HDR;
    end else begin
      case (st_q)
        VTF_ST_IDLE: begin
          st_d = VTF_ST_IDLE;
        end
        VTF_ST_HDR: begin
          if (at_outer_tpid_w) begin
            if (tpid_is_stag(word_w)) begin
              st_d = VTF_ST_STAG;
            end else if (tpid_is_ctag(word_w)) begin
              st_d = VTF_ST_CTAG;
            end else begin
              st_d = VTF_ST_SKIP;
            end
          end
        end
        VTF_ST_STAG: begin
          if (at_inner_tpid_w) begin
            st_d = tpid_is_ctag(word_w) ? VTF_ST_CTAG : VTF_ST_SKIP;
          end
        end
        VTF_ST_CTAG: begin
          if (c_cap_w) begin
            st_d = VTF_ST_SKIP;
          end
        end
        VTF_ST_SKIP: begin
          st_d = VTF_ST_SKIP;
        end
        default: begin
          st_d = VTF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= VTF_ST_IDLE;
      cnt_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (take_w) begin
        cnt_q <= cnt_next_w;
        prev_q <= i_rx_data;
      end
    end
  end

  // ****************************************
  // Tag capture
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      has_s_q <= 1'h0;
      has_c_q <= 1'h0;
      s_tci_q <= 16'h0000;
      c_tci_q <= 16'h0000;
    end else if (restart_w) begin
      has_s_q <= 1'h0;
      has_c_q <= 1'h0;
    end else begin
      if (s_cap_w) begin
        has_s_q <= 1'h1;
        s_tci_q <= word_w;
      end
      if (c_cap_w) begin
        has_c_q <= 1'h1;
        c_tci_q <= word_w;
      end
    end
  end

  // ****************************************
  // Settings snapshot
  // ****************************************
  // Held for the whole frame so a setting change mid-frame cannot mix two setups
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      svid_mode_q <= VTF_IGNORE;
      spcp_mode_q <= VTF_IGNORE;
      sdei_mode_q <= VTF_IGNORE;
      cvid_mode_q <= VTF_IGNORE;
      cpcp_mode_q <= VTF_IGNORE;
      svid_val_q <= 10'h000;
      cvid_val_q <= 10'h000;
      spcp_val_q <= 3'h0;
      cpcp_val_q <= 3'h0;
      sdei_val_q <= 1'h0;
    end else if (restart_w) begin
      svid_mode_q <= i_svid_mode;
      spcp_mode_q <= i_spcp_mode;
      sdei_mode_q <= i_sdei_mode;
      cvid_mode_q <= i_cvid_mode;
      cpcp_mode_q <= i_cpcp_mode;
      svid_val_q <= i_svid_value;
      cvid_val_q <= i_cvid_value;
      spcp_val_q <= i_spcp_value;
      cpcp_val_q <= i_cpcp_value;
      sdei_val_q <= i_sdei_value;
    end
  end

  // ****************************************
  // Tag level selection
  // ****************************************
  assign double_w = has_s_q & has_c_q;
  assign lone_w = has_s_q ^ has_c_q;
  // Service rules see only the outer tag of a double-tagged frame
  assign s_present_w = double_w;
  assign s_tci_w = s_tci_q;
  // A single tag of either kind is judged as the customer tag
  assign c_present_w = double_w | lone_w;
  assign c_tci_w = has_c_q ? c_tci_q : s_tci_q;

  // ****************************************
  // Rule table
  // ****************************************
  assign mode_a[`VTF_R_SVID] = svid_mode_q;
  assign want_a[`VTF_R_SVID] = {2'h0, svid_val_q};
  assign field_a[`VTF_R_SVID] = tci_vid(s_tci_w);
  assign present_a[`VTF_R_SVID] = s_present_w;

  assign mode_a[`VTF_R_SPCP] = spcp_mode_q;
  assign want_a[`VTF_R_SPCP] = {9'h000, spcp_val_q};
  assign field_a[`VTF_R_SPCP] = tci_pcp(s_tci_w);
  assign present_a[`VTF_R_SPCP] = s_present_w;

  assign mode_a[`VTF_R_SDEI] = sdei_mode_q;
  assign want_a[`VTF_R_SDEI] = {11'h000, sdei_val_q};
  assign field_a[`VTF_R_SDEI] = tci_dei(s_tci_w);
  assign present_a[`VTF_R_SDEI] = s_present_w;

  assign mode_a[`VTF_R_CVID] = cvid_mode_q;
  assign want_a[`VTF_R_CVID] = {2'h0, cvid_val_q};
  assign field_a[`VTF_R_CVID] = tci_vid(c_tci_w);
  assign present_a[`VTF_R_CVID] = c_present_w;

  assign mode_a[`VTF_R_CPCP] = cpcp_mode_q;
  assign want_a[`VTF_R_CPCP] = {9'h000, cpcp_val_q};
  assign field_a[`VTF_R_CPCP] = tci_pcp(c_tci_w);
  assign present_a[`VTF_R_CPCP] = c_present_w;

  genvar gi;
  generate
    for (gi = 0; gi < `VTF_NRULE; gi = gi + 1) begin : g_rule
      vtf_rule_cmp u_cmp (
        .i_mode(mode_a[gi]),
        .i_want(want_a[gi]),
        .i_present(present_a[gi]),
        .i_field(field_a[gi]),
        .o_enabled(en_w[gi]),
        .o_hit(hit_w[gi])
      );
    end
  endgenerate

  // ****************************************
  // Verdict
  // ****************************************
  // With every rule ignored the filter selects no frame
  assign any_en_w = (|en_w) | ext_en_q;
  assign all_ok_w = (&(hit_w | ~en_w)) & (~ext_en_q | ext_hit_q);
  assign pass_w = any_en_w & all_ok_w;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      eval_q <= 1'h0;
      ext_en_q <= 1'h0;
      ext_hit_q <= 1'h0;
    end else begin
      eval_q <= last_w & frame_live_w;
      ext_en_q <= i_ext_rule_en;
      ext_hit_q <= i_ext_rule_hit;
    end
  end

  // Verdict holds until the next frame is judged
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      verdict_valid_q <= 1'h0;
      pass_q <= 1'h0;
      block_q <= 1'h0;
      tag_count_q <= 2'h0;
      rule_en_q <= '0;
      rule_hit_q <= '0;
    end else begin
      verdict_valid_q <= eval_q;
      if (eval_q) begin
        pass_q <= pass_w;
        block_q <= ~pass_w;
        tag_count_q <= {double_w, lone_w};
        rule_en_q <= en_w;
        rule_hit_q <= hit_w;
      end
    end
  end

  assign o_verdict_valid = verdict_valid_q;
  assign o_pass = pass_q;
  assign o_block = block_q;
  assign o_tag_count = tag_count_q;
  assign o_rule_en = rule_en_q;
  assign o_rule_hit = rule_hit_q;

endmodule

//--- testbench/vtf_filter_assertions.sv
// Checker of the tag frame filter verdict outputs
`include "vtf_cfg.svh"

module vtf_filter_assertions (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_rx_valid,
  input wire logic i_rx_eof,
  input wire logic i_ext_rule_en,
  input wire logic o_verdict_valid,
  input wire logic o_pass,
  input wire logic o_block,
  input wire logic [1:0] o_tag_count,
  input wire logic [`VTF_NRULE-1:0] o_rule_en,
  input wire logic [`VTF_NRULE-1:0] o_rule_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // ****
  // Verdict checks
  // ****
  // Eof byte is taken two samples before the pulse is seen
  property p_timing;
    o_verdict_valid |-> $past(i_rx_valid && i_rx_eof, 2);
  endproperty
  a_timing: assert property (p_timing) else $error("verdict not timed to eof");
  property p_tags;
    o_verdict_valid |-> o_tag_count != 2'h3;
  endproperty
  a_tags: assert property (p_tags) else $error("bad tag count");
  property p_compl;
    o_verdict_valid |-> o_block == !o_pass;
  endproperty
  a_compl: assert property (p_compl) else $error("pass and block disagree");
  property p_all_hit;
    o_verdict_valid && o_pass |-> (o_rule_en & ~o_rule_hit) == 5'h00;
  endproperty
  a_all_hit: assert property (p_all_hit) else $error("pass with a missed rule");
  property p_none;
    o_verdict_valid && o_rule_en == 5'h00 && !$past(i_ext_rule_en, 2) |-> !o_pass;
  endproperty
  a_none: assert property (p_none) else $error("pass with no rule enabled");
  property p_hold;
    !o_verdict_valid |-> $stable({o_pass, o_block, o_tag_count, o_rule_en, o_rule_hit});
  endproperty
  a_hold: assert property (p_hold) else $error("verdict moved between pulses");
  property p_svc;
    o_verdict_valid && o_tag_count != 2'h2 |-> o_rule_hit[2:0] == 3'h0;
  endproperty
  a_svc: assert property (p_svc) else $error("service hit without two tags");
  property p_bare;
    o_verdict_valid && o_tag_count == 2'h0 |-> o_rule_hit == 5'h00;
  endproperty
  a_bare: assert property (p_bare) else $error("hit on untagged frame");
endmodule

bind vtf_filter vtf_filter_assertions u_chk (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_rx_valid(i_rx_valid),
  .i_rx_eof(i_rx_eof),
  .i_ext_rule_en(i_ext_rule_en),
  .o_verdict_valid(o_verdict_valid),
  .o_pass(o_pass),
  .o_block(o_block),
  .o_tag_count(o_tag_count),
  .o_rule_en(o_rule_en),
  .o_rule_hit(o_rule_hit)
);

//--- testbench/vtf_link_model.sv
// Link model: delivers received frame bytes to the filter
module vtf_link_model (
  // Clock
  input wire logic i_sys_clk,
  // Byte stream
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_sof,
  output logic o_rx_eof
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h5a;
    o_rx_sof = 1'b0;
    o_rx_eof = 1'b0;
  end
  // Idle data keeps changing so a stale byte is never mistaken for a fresh one
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b0;
      o_rx_sof <= 1'b0;
      o_rx_eof <= 1'b0;
      o_rx_data <= ~o_rx_data;
    end
  endtask
  // Gap inserts stall cycles before every byte; the last byte is left on the line
  task automatic send(input logic [7:0] fr [$], input int gap);
    for (int i = 0; i < fr.size(); i++) begin
      idle(gap);
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= fr[i];
      o_rx_sof <= (i == 0);
      o_rx_eof <= (i == fr.size() - 1);
    end
  endtask
endmodule

//--- testbench/testbench.sv
// Testbench of the tag frame filter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vtf_pkg::*;
  logic clk;
  logic rst;
  logic [4:0] modes;
  logic [9:0] sv;
  logic [9:0] cv;
  logic [2:0] sp;
  logic [2:0] cp;
  logic sd;
  logic xe;
  logic xh;
  wire rx_valid;
  wire rx_sof;
  wire rx_eof;
  wire [7:0] rx_data;
  wire vv;
  wire pass;
  wire blk;
  wire [1:0] tc;
  wire [4:0] ren;
  wire [4:0] rhit;
  logic [13:0] exp_list [$];
  logic [13:0] got_list [$];
  int failures;
  int compares;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  vtf_link_model link (.i_sys_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_sof(rx_sof), .o_rx_eof(rx_eof));
  vtf_filter dut (.i_sys_clk(clk), .i_rst(rst), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_sof(rx_sof), .i_rx_eof(rx_eof), .i_svid_mode(vtf_mode_type'(modes[0])),
    .i_svid_value(sv), .i_spcp_mode(vtf_mode_type'(modes[1])), .i_spcp_value(sp),
    .i_sdei_mode(vtf_mode_type'(modes[2])), .i_sdei_value(sd),
    .i_cvid_mode(vtf_mode_type'(modes[3])), .i_cvid_value(cv),
    .i_cpcp_mode(vtf_mode_type'(modes[4])), .i_cpcp_value(cp), .i_ext_rule_en(xe),
    .i_ext_rule_hit(xh), .o_verdict_valid(vv), .o_pass(pass), .o_block(blk), .o_tag_count(tc),
    .o_rule_en(ren), .o_rule_hit(rhit));
  // ****
  // Tasks
  // ****
  always @(posedge clk) begin
    if (vv === 1'b1) begin
      got_list.push_back({pass, blk, tc, ren, rhit & ren});
    end
  end
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic set(input logic [4:0] m, input logic [9:0] s_v, input logic [2:0] s_p,
    input logic s_d, input logic [9:0] c_v, input logic [2:0] c_p, input logic e, input logic h);
    @(posedge clk);
    modes <= m;
    sv <= s_v;
    sp <= s_p;
    sd <= s_d;
    cv <= c_v;
    cp <= c_p;
    xe <= e;
    xh <= h;
    @(negedge clk);
  endtask
  // Expected verdict is worked out from the tag layout and queued before sending
  task automatic frame(input logic [15:0] t1, input logic [15:0] c1, input logic [15:0] t2,
    input logic [15:0] c2, input int gap);
    logic [7:0] fr [$];
    logic [63:0] hdr;
    logic dbl;
    logic one;
    logic [15:0] ct;
    logic [4:0] hit;
    logic ok;
    hdr = {t1, c1, t2, c2};
    for (int i = 0; i < 64; i++) begin
      fr.push_back(8'(i * 37 + 5));
    end
    for (int i = 0; i < 8; i++) begin
      fr[12 + i] = hdr[63 - 8 * i -: 8];
    end
    dbl = (t1 == 16'h88a8) && (t2 == 16'h8100);
    one = !dbl && (t1 == 16'h8100 || t1 == 16'h88a8);
    ct = dbl ? c2 : c1;
    hit[0] = dbl && c1[11:0] == {2'h0, sv};
    hit[1] = dbl && c1[15:13] == sp;
    hit[2] = dbl && c1[12] == sd;
    hit[3] = (dbl || one) && ct[11:0] == {2'h0, cv};
    hit[4] = (dbl || one) && ct[15:13] == cp;
    ok = (|modes || xe) && (modes & ~hit) == 5'h00 && (!xe || xh);
    exp_list.push_back({ok, !ok, dbl, one, modes, hit & modes});
    link.send(fr, gap);
  endtask
  task automatic check();
    logic [13:0] e;
    logic [13:0] g;
    link.idle(6);
    compares++;
    if (got_list.size() != exp_list.size()) begin
      failures++;
      $display("unexpected verdict count expected %0d seen %0d", exp_list.size(), got_list.size());
    end
    while (exp_list.size() > 0 && got_list.size() > 0) begin
      e = exp_list.pop_front();
      g = got_list.pop_front();
      compares++;
      if (g !== e) begin
        failures++;
        $display("unexpected verdict expected %h seen %h", e, g);
      end
    end
    exp_list.delete();
    got_list.delete();
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {modes, sv, sp, sd, cv, cp, xe, xh} = 34'h0;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    set(5'h00, 10'h000, 3'h0, 1'b0, 10'h000, 3'h0, 1'b0, 1'b0);
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 0);
    frame(16'h8100, 16'h0000, 16'h0800, 16'h0000, 1);
    check();
    set(5'h08, 10'h123, 3'h0, 1'b0, 10'h123, 3'h0, 1'b0, 1'b0);
    frame(16'h8100, 16'h0123, 16'h0800, 16'h0000, 0);
    frame(16'h8100, 16'h0124, 16'h0800, 16'h0000, 0);
    frame(16'h8100, 16'h0523, 16'h0800, 16'h0000, 2);
    frame(16'h88a8, 16'h0123, 16'h0800, 16'h0000, 0);
    check();
    set(5'h1f, 10'h2a5, 3'h5, 1'b1, 10'h3ff, 3'h2, 1'b0, 1'b0);
    frame(16'h88a8, 16'hb2a5, 16'h8100, 16'h43ff, 0);
    frame(16'h88a8, 16'ha2a5, 16'h8100, 16'h43ff, 0);
    frame(16'h88a8, 16'h92a5, 16'h8100, 16'h43ff, 0);
    frame(16'h88a8, 16'hb2a4, 16'h8100, 16'h43ff, 0);
    frame(16'h88a8, 16'hb2a5, 16'h8100, 16'h63ff, 0);
    check();
    set(5'h01, 10'h055, 3'h0, 1'b0, 10'h000, 3'h0, 1'b0, 1'b0);
    frame(16'h8100, 16'h0055, 16'h0800, 16'h0000, 0);
    check();
    set(5'h04, 10'h000, 3'h0, 1'b1, 10'h000, 3'h0, 1'b0, 1'b0);
    frame(16'h8100, 16'h1000, 16'h0800, 16'h0000, 0);
    frame(16'h88a8, 16'h1000, 16'h8100, 16'h0000, 0);
    check();
    set(5'h12, 10'h000, 3'h3, 1'b0, 10'h000, 3'h3, 1'b0, 1'b0);
    frame(16'h8100, 16'h6001, 16'h0800, 16'h0000, 0);
    frame(16'h88a8, 16'h6001, 16'h8100, 16'h6002, 1);
    check();
    set(5'h00, 10'h000, 3'h0, 1'b0, 10'h000, 3'h0, 1'b1, 1'b1);
    frame(16'h0800, 16'h0000, 16'h0000, 16'h0000, 0);
    check();
    set(5'h08, 10'h000, 3'h0, 1'b0, 10'h0aa, 3'h0, 1'b1, 1'b0);
    frame(16'h8100, 16'h00aa, 16'h0800, 16'h0000, 0);
    check();
    set(5'h08, 10'h000, 3'h0, 1'b0, 10'h0aa, 3'h0, 1'b1, 1'b1);
    frame(16'h8100, 16'h00aa, 16'h0800, 16'h0000, 0);
    frame(16'h0800, 16'h00aa, 16'h0800, 16'h0000, 0);
    check();
    summarize();
  end
endmodule
